// File: tsa_map.svh
// Purpose: named offsets, fields, reset values and timing counts of the sensor address/event block
// Assumes: included by its bare name by the event, device and master ends and the bench
// Notes: definitions only
//
// Overview of operation
// - eeprom and sensor paths work independently
// - address byte msb first: type, strap bits, direction
// - type 1010 selects the eeprom array
// - type 0110 selects eeprom page and protect functions
// - exactly three types; 0011 selects sensor registers
// - three address bits must equal strap pins
// - address bit zero one reads, zero writes
// - ack on match, else nack and standby
// - new temperature latched at least eight times per second
// - data pin open drain only, bus up to 1MHz
// - event output has interrupt, comparator, critical behaviours
// - interrupt holds until config bit five written one
// - back inside limits, config bit zero picks behaviour
// - comparator event follows the causing condition
// - critical holds until below limit minus hysteresis
// - all thresholds use programmed hysteresis
// - enabled event fires entering or leaving limit window
// - 8-bit pointer selects 16-bit registers
// - write-only reads zero; read-only writes acked, ignored
// - pointer map 00h to 07h, listed reset values
// - master avoids writing pointers 08h to 0Fh
// - pointer is zero after power on
`ifndef TSA_MAP_SVH
`define TSA_MAP_SVH

// ----------------------------------------------------------------
// register pointers and reset values
// ----------------------------------------------------------------
`define TSA_PTR_CAP 8'h00
`define TSA_PTR_CFG 8'h01
`define TSA_PTR_UP 8'h02
`define TSA_PTR_LO 8'h03
`define TSA_PTR_CRIT 8'h04
`define TSA_PTR_TEMP 8'h05
`define TSA_PTR_MAKER 8'h06
`define TSA_PTR_PART 8'h07
`define TSA_PTR_RST 8'h00
`define TSA_CAP_RST 16'h00f7
`define TSA_REG_RST 16'h0000
`define TSA_CFG_WMASK 16'h07cf

// ----------------------------------------------------------------
// address byte types and config fields
// ----------------------------------------------------------------
`define TSA_TYPE_EE 4'ha
`define TSA_TYPE_EEFN 4'h6
`define TSA_TYPE_TS 4'h3
`define TSA_CFG_MODE 0
`define TSA_CFG_POL 1
`define TSA_CFG_CRIT 2
`define TSA_CFG_EN 3
`define TSA_CFG_STS 4
`define TSA_CFG_CLR 5
`define TSA_CFG_HYS_LO 9
`define TSA_CFG_HYS_HI 10
`define TSA_TEMP_MSB 12
`define TSA_HYS_OFF 15'h0000
`define TSA_HYS_1P5 15'h0018
`define TSA_HYS_3 15'h0030
`define TSA_HYS_6 15'h0060
`define TSA_ACK_BIT 4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TSA_CLK_HZ 20000000
`define TSA_SCL_MAX_HZ 1000000
`define TSA_SCL_QTR_CYC (`TSA_CLK_HZ / (4 * `TSA_SCL_MAX_HZ))
`define TSA_CONV_MS 125
`define TSA_CONV_CYC ((`TSA_CLK_HZ / 1000) * `TSA_CONV_MS)

`endif

// File: tsa_pkg.sv
// Purpose: types shared by the sensor address/event ends
// Assumes: nothing
// Notes: no numbers here, see tsa_map.svh
`default_nettype none
package tsa_pkg;
  typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_WRITE, DS_READ} tsa_dev_st_e;
  typedef enum logic [1:0] {TG_NONE, TG_TS, TG_EE, TG_EEFN} tsa_tgt_e;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} tsa_host_st_e;
endpackage
`default_nettype wire

// File: tsa_bus_if.sv
// Purpose: two-wire bus and event line between master and sensor
// Assumes: pull-ups on data and event lines
// Notes: oe_n low means the party pulls the line to its _o level
`default_nettype none
interface tsa_bus_if;
  logic scl;
  logic sda;
  logic evt_line;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic d_evt_o;
  logic d_evt_oe_n;

  assign sda = !((!h_sda_oe_n && !h_sda_o) || (!d_sda_oe_n && !d_sda_o));
  assign evt_line = !(!d_evt_oe_n && !d_evt_o);

  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n, output d_evt_o, output d_evt_oe_n);
  modport host (output scl, output h_sda_o, output h_sda_oe_n, input sda, input evt_line);
endinterface
`default_nettype wire

// File: tsa_event.sv
// Purpose: limit compare with hysteresis and event pin behaviours
// Assumes: upd pulses with temp holding the newly latched measurement
// Notes: pin is open drain, active level from config polarity
`include "tsa_map.svh"
`default_nettype none
module tsa_event
  import tsa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [15:0] temp,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic [15:0] crit,
  input wire logic [15:0] cfg,
  input wire logic upd,
  input wire logic clr,
  output logic evt_r,
  output logic pin_oe_n_r
);
  logic hi_r, lo_r, cr_r, irq_r;
  logic hi_nxt, lo_nxt, cr_nxt, irq_nxt, evt_nxt, pin_oe_n_nxt;
  logic signed [14:0] t, hys;

  function automatic logic signed [14:0] ext(input logic [15:0] v);
    ext = signed'({{2{v[`TSA_TEMP_MSB]}}, v[`TSA_TEMP_MSB:0]});
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    t = ext(temp);
    case (cfg[`TSA_CFG_HYS_HI:`TSA_CFG_HYS_LO])
      2'h1: hys = `TSA_HYS_1P5;
      2'h2: hys = `TSA_HYS_3;
      2'h3: hys = `TSA_HYS_6;
      default: hys = `TSA_HYS_OFF;
    endcase
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    cr_nxt = cr_r;
    if (upd)
    begin
      if (t > ext(upper))
        hi_nxt = 1'b1;
      else if (t < ext(upper) - hys)
        hi_nxt = 1'b0;
      if (t < ext(lower))
        lo_nxt = 1'b1;
      else if (t > ext(lower) + hys)
        lo_nxt = 1'b0;
      if (t > ext(crit))
        cr_nxt = 1'b1;
      else if (t < ext(crit) - hys)
        cr_nxt = 1'b0;
    end
    // window entry or exit sets the latch; set wins over clear
    irq_nxt = (irq_r && !clr) ||
              (upd && cfg[`TSA_CFG_EN] && ((hi_nxt || lo_nxt) != (hi_r || lo_r)));
    // critical dominates; otherwise, with bit two clear, bit zero picks latch or live level
    evt_nxt = cfg[`TSA_CFG_EN] && (cr_nxt || (!cfg[`TSA_CFG_CRIT] &&
              (cfg[`TSA_CFG_MODE] ? irq_nxt : (hi_nxt || lo_nxt))));
    pin_oe_n_nxt = evt_nxt ~^ cfg[`TSA_CFG_POL];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
      cr_r <= 1'b0;
      irq_r <= 1'b0;
      evt_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end
    else if (ce)
    begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      cr_r <= cr_nxt;
      irq_r <= irq_nxt;
      evt_r <= evt_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
    end
  end
endmodule
`default_nettype wire

// File: tsa_dev.sv
// Purpose: sensor device end: address decode, pointer registers, event pin
// Assumes: scl and sda are asynchronous pins, temp_code comes from a converter on clk_sys
// Notes: eeprom array itself lives outside; this end only routes bytes to it
`include "tsa_map.svh"
`default_nettype none
module tsa_dev
  import tsa_pkg::*;
#(
  parameter int CONV_CYC = `TSA_CONV_CYC,
  parameter logic [15:0] MAKER_CODE = 16'h0a5a,  // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0c3c  // arbitrary value
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  tsa_bus_if.dev bus,
  input wire logic strap_addr_bit2,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit0,
  input wire logic [15:0] temp_code,
  input wire logic temp_valid,
  input wire logic [7:0] ee_rd_data,
  output logic conv_req,
  output logic [1:0] ee_sel,
  output logic ee_rw,
  output logic [7:0] ee_wr_data,
  output logic ee_wr_valid
);
  // ----------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  logic [2:0] strap_s1, strap_s2;
  logic start_p, stop_p, rise_p, fall_p;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end
    else if (ce)
    begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
      strap_s1 <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      strap_s2 <= strap_s1;
    end
  end

  assign start_p = scl_s2 && scl_q && sda_q && !sda_s2;
  assign stop_p = scl_s2 && scl_q && !sda_q && sda_s2;
  assign rise_p = scl_s2 && !scl_q;
  assign fall_p = !scl_s2 && scl_q;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic tsa_tgt_e decode(input logic [7:0] a, input logic [2:0] strap);
    decode = TG_NONE;
    if (a[3:1] == strap)
    begin
      case (a[7:4])
        `TSA_TYPE_EE: decode = TG_EE;
        `TSA_TYPE_EEFN: decode = TG_EEFN;
        `TSA_TYPE_TS: decode = TG_TS;
        default: decode = TG_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // serial engine and register file
  // ----------------------------------------------------------------
  tsa_dev_st_e st_r, st_nxt;
  tsa_tgt_e tgt_r, tgt_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, hi_r, hi_nxt;
  logic [7:0] ee_wr_data_nxt;
  logic [1:0] wcnt_r, wcnt_nxt;
  logic oe_n_r, oe_n_nxt, mack_r, mack_nxt, rd_lo_r, rd_lo_nxt, rw_r, rw_nxt;
  logic clr_r, clr_nxt, ee_wr_valid_nxt;
  logic [15:0] cfg_r, cfg_nxt, up_r, up_nxt, lo_r, lo_nxt, cr_r, cr_nxt, temp_r, temp_nxt;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;
  logic evt_sts, evt_oe_n;

  always_comb
  begin
    case (ptr_r)
      `TSA_PTR_CAP: rd_word = `TSA_CAP_RST;
      `TSA_PTR_CFG: rd_word = cfg_r | (16'(evt_sts) << `TSA_CFG_STS);
      `TSA_PTR_UP: rd_word = up_r;
      `TSA_PTR_LO: rd_word = lo_r;
      `TSA_PTR_CRIT: rd_word = cr_r;
      `TSA_PTR_TEMP: rd_word = temp_r;
      `TSA_PTR_MAKER: rd_word = MAKER_CODE;
      `TSA_PTR_PART: rd_word = PART_CODE;
      default: rd_word = `TSA_REG_RST;
    endcase
    if (tgt_r == TG_TS)
      tx_byte = rd_lo_r ? rd_word[7:0] : rd_word[15:8];
    else
      tx_byte = ee_rd_data;

    st_nxt = st_r;
    tgt_nxt = tgt_r;
    bitcnt_nxt = bitcnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    hi_nxt = hi_r;
    wcnt_nxt = wcnt_r;
    oe_n_nxt = oe_n_r;
    mack_nxt = mack_r;
    rd_lo_nxt = rd_lo_r;
    rw_nxt = rw_r;
    cfg_nxt = cfg_r;
    up_nxt = up_r;
    lo_nxt = lo_r;
    cr_nxt = cr_r;
    temp_nxt = temp_valid ? temp_code : temp_r;
    clr_nxt = 1'b0;
    ee_wr_valid_nxt = 1'b0;
    ee_wr_data_nxt = ee_wr_data;

    if (start_p || stop_p)
    begin
      st_nxt = start_p ? DS_ADDR : DS_IDLE;
      tgt_nxt = TG_NONE;
      bitcnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
      mack_nxt = 1'b0;
    end
    else if (rise_p && st_r != DS_IDLE)
    begin
      if (bitcnt_r != `TSA_ACK_BIT)
      begin
        sh_nxt = {sh_r[6:0], sda_s2};
        bitcnt_nxt = bitcnt_r + 4'h1;
      end
      else
      begin
        bitcnt_nxt = 4'h0;
        mack_nxt = 1'b0;
        if (mack_r && sda_s2)
          st_nxt = DS_IDLE;
      end
    end
    else if (fall_p && st_r != DS_IDLE)
    begin
      oe_n_nxt = 1'b1;
      if (bitcnt_r == `TSA_ACK_BIT)
      begin
        case (st_r)
          DS_ADDR:
          begin
            tgt_nxt = decode(sh_r, strap_s2);
            if (decode(sh_r, strap_s2) == TG_NONE)
              st_nxt = DS_IDLE;
            else
            begin
              oe_n_nxt = 1'b0;
              rw_nxt = sh_r[0];
              st_nxt = sh_r[0] ? DS_READ : DS_WRITE;
              rd_lo_nxt = 1'b0;
              wcnt_nxt = 2'h0;
            end
          end
          DS_WRITE:
          begin
            oe_n_nxt = 1'b0;
            if (tgt_r == TG_TS)
            begin
              if (wcnt_r != 2'h3)
                wcnt_nxt = wcnt_r + 2'h1;
              case (wcnt_r)
                2'h0: ptr_nxt = sh_r;
                2'h1: hi_nxt = sh_r;
                2'h2:
                begin
                  // read-only and reserved pointers ack but keep contents
                  case (ptr_r)
                    `TSA_PTR_CFG:
                    begin
                      cfg_nxt = {hi_r, sh_r} & `TSA_CFG_WMASK;
                      clr_nxt = sh_r[`TSA_CFG_CLR];
                    end
                    `TSA_PTR_UP: up_nxt = {hi_r, sh_r};
                    `TSA_PTR_LO: lo_nxt = {hi_r, sh_r};
                    `TSA_PTR_CRIT: cr_nxt = {hi_r, sh_r};
                    default: cfg_nxt = cfg_r;
                  endcase
                end
                default: wcnt_nxt = wcnt_r;
              endcase
            end
            else
            begin
              ee_wr_data_nxt = sh_r;
              ee_wr_valid_nxt = 1'b1;
            end
          end
          DS_READ: mack_nxt = 1'b1;
          default: st_nxt = DS_IDLE;
        endcase
      end
      else if (st_r == DS_READ)
      begin
        if (bitcnt_r == 4'h0)
        begin
          tx_nxt = tx_byte;
          rd_lo_nxt = !rd_lo_r;
          oe_n_nxt = tx_byte[7];
        end
        else
          oe_n_nxt = tx_r[3'(4'h7 - bitcnt_r)];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= DS_IDLE;
      tgt_r <= TG_NONE;
      bitcnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= `TSA_PTR_RST;
      hi_r <= 8'h00;
      wcnt_r <= 2'h0;
      oe_n_r <= 1'b1;
      mack_r <= 1'b0;
      rd_lo_r <= 1'b0;
      rw_r <= 1'b0;
      cfg_r <= `TSA_REG_RST;
      up_r <= `TSA_REG_RST;
      lo_r <= `TSA_REG_RST;
      cr_r <= `TSA_REG_RST;
      temp_r <= `TSA_REG_RST;
      clr_r <= 1'b0;
      ee_wr_valid <= 1'b0;
      ee_wr_data <= 8'h00;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      tgt_r <= tgt_nxt;
      bitcnt_r <= bitcnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      hi_r <= hi_nxt;
      wcnt_r <= wcnt_nxt;
      oe_n_r <= oe_n_nxt;
      mack_r <= mack_nxt;
      rd_lo_r <= rd_lo_nxt;
      rw_r <= rw_nxt;
      cfg_r <= cfg_nxt;
      up_r <= up_nxt;
      lo_r <= lo_nxt;
      cr_r <= cr_nxt;
      temp_r <= temp_nxt;
      clr_r <= clr_nxt;
      ee_wr_valid <= ee_wr_valid_nxt;
      ee_wr_data <= ee_wr_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // measurement request timer
  // ----------------------------------------------------------------
  logic [21:0] conv_cnt_r, conv_cnt_nxt;
  logic conv_req_nxt;

  always_comb
  begin
    conv_req_nxt = (conv_cnt_r == 22'(CONV_CYC - 1));
    conv_cnt_nxt = conv_req_nxt ? 22'h000000 : conv_cnt_r + 22'h000001;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      conv_cnt_r <= 22'h000000;
      conv_req <= 1'b0;
    end
    else if (ce)
    begin
      conv_cnt_r <= conv_cnt_nxt;
      conv_req <= conv_req_nxt;
    end
  end

  // ----------------------------------------------------------------
  // event pin and outputs
  // ----------------------------------------------------------------
  tsa_event u_event (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .temp(temp_code),
    .upper(up_r),
    .lower(lo_r),
    .crit(cr_r),
    .cfg(cfg_r),
    .upd(temp_valid),
    .clr(clr_r),
    .evt_r(evt_sts),
    .pin_oe_n_r(evt_oe_n)
  );

  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe_n = oe_n_r;
  assign bus.d_evt_o = 1'b0;
  assign bus.d_evt_oe_n = evt_oe_n;
  assign ee_sel = (tgt_r == TG_EE) ? 2'h1 : ((tgt_r == TG_EEFN) ? 2'h2 : 2'h0);
  assign ee_rw = rw_r;
endmodule
`default_nettype wire

// File: tsa_host.sv
// Purpose: two-wire master end for the sensor device
// Assumes: one command at a time, stop after each command
// Notes: scl made by a divider from clk_sys, never stretched
`include "tsa_map.svh"
`default_nettype none
module tsa_host
  import tsa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  tsa_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_rw,
  input wire logic [1:0] cmd_nbytes,
  input wire logic [23:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_nack
);
  tsa_host_st_e st_r, st_nxt;
  logic [7:0] div_r, div_nxt, sh_r, sh_nxt;
  logic [1:0] q_r, q_nxt, left_r, left_nxt;
  logic [3:0] bitn_r, bitn_nxt;
  logic [23:0] wbuf_r, wbuf_nxt;
  logic [15:0] rsp_data_nxt;
  logic rw_r, rw_nxt, is_addr_r, is_addr_nxt, nack_r, nack_nxt;
  logic scl_r, scl_nxt, oe_n_r, oe_n_nxt, rsp_valid_nxt, rsp_nack_nxt;
  logic sda_s1, sda_s2, tick, sending;

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  always_comb
  begin
    tick = (div_r == 8'(`TSA_SCL_QTR_CYC - 1));
    sending = is_addr_r || !rw_r;
    cmd_ready = (st_r == HS_IDLE);
    st_nxt = st_r;
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
    q_nxt = tick ? q_r + 2'h1 : q_r;
    sh_nxt = sh_r;
    left_nxt = left_r;
    bitn_nxt = bitn_r;
    wbuf_nxt = wbuf_r;
    rw_nxt = rw_r;
    is_addr_nxt = is_addr_r;
    nack_nxt = nack_r;
    scl_nxt = scl_r;
    oe_n_nxt = oe_n_r;
    rsp_valid_nxt = 1'b0;
    rsp_nack_nxt = rsp_nack;
    rsp_data_nxt = rsp_data;
    case (st_r)
      HS_IDLE:
      begin
        div_nxt = 8'h00;
        q_nxt = 2'h0;
        if (cmd_valid)
        begin
          st_nxt = HS_START;
          sh_nxt = {cmd_addr, cmd_rw};
          rw_nxt = cmd_rw;
          left_nxt = cmd_nbytes;
          wbuf_nxt = cmd_wdata;
          is_addr_nxt = 1'b1;
          nack_nxt = 1'b0;
          bitn_nxt = 4'h0;
          rsp_data_nxt = 16'h0000;
        end
      end
      HS_START:
        if (tick)
        begin
          if (q_r == 2'h0)
            oe_n_nxt = 1'b0;
          else
          begin
            scl_nxt = 1'b0;
            st_nxt = HS_BIT;
            q_nxt = 2'h0;
          end
        end
      HS_BIT:
        if (tick)
        begin
          case (q_r)
            2'h0:
              if (bitn_r != `TSA_ACK_BIT)
                oe_n_nxt = sending ? sh_r[7] : 1'b1;
              else
                oe_n_nxt = sending || (left_r == 2'h1);
            2'h1: scl_nxt = 1'b1;
            2'h2:
              if (bitn_r != `TSA_ACK_BIT)
                sh_nxt = {sh_r[6:0], sda_s2};
              else if (sending)
                nack_nxt = sda_s2;
            default:
            begin
              scl_nxt = 1'b0;
              bitn_nxt = bitn_r + 4'h1;
              if (bitn_r == `TSA_ACK_BIT)
              begin
                bitn_nxt = 4'h0;
                is_addr_nxt = 1'b0;
                if (!is_addr_r)
                  left_nxt = left_r - 2'h1;
                if (rw_r && !is_addr_r)
                  rsp_data_nxt = {rsp_data[7:0], sh_r};
                if (nack_r || (is_addr_r ? left_r == 2'h0 : left_r == 2'h1))
                  st_nxt = HS_STOP;
                else if (!rw_r)
                begin
                  sh_nxt = wbuf_r[23:16];
                  wbuf_nxt = {wbuf_r[15:0], 8'h00};
                end
              end
            end
          endcase
        end
      default:
        if (tick)
        begin
          case (q_r)
            2'h0: oe_n_nxt = 1'b0;
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_n_nxt = 1'b1;
            default:
            begin
              st_nxt = HS_IDLE;
              rsp_valid_nxt = 1'b1;
              rsp_nack_nxt = nack_r;
            end
          endcase
        end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= HS_IDLE;
      div_r <= 8'h00;
      q_r <= 2'h0;
      sh_r <= 8'h00;
      left_r <= 2'h0;
      bitn_r <= 4'h0;
      wbuf_r <= 24'h000000;
      rw_r <= 1'b0;
      is_addr_r <= 1'b0;
      nack_r <= 1'b0;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_data <= 16'h0000;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      q_r <= q_nxt;
      sh_r <= sh_nxt;
      left_r <= left_nxt;
      bitn_r <= bitn_nxt;
      wbuf_r <= wbuf_nxt;
      rw_r <= rw_nxt;
      is_addr_r <= is_addr_nxt;
      nack_r <= nack_nxt;
      scl_r <= scl_nxt;
      oe_n_r <= oe_n_nxt;
      rsp_valid <= rsp_valid_nxt;
      rsp_nack <= rsp_nack_nxt;
      rsp_data <= rsp_data_nxt;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  assign bus.scl = scl_r;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_sda_oe_n = oe_n_r;
endmodule
`default_nettype wire

// File: tsa_props.sv
// Purpose: pin checks on the link between master and sensor ends
// Assumes: signals of tsa_bus_if, clk_sys at 20MHz
// Notes: instantiated beside the interface
`default_nettype none
module tsa_props (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic d_evt_o,
  input wire logic d_evt_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_sod; d_sda_o == 1'b0; endproperty
  a_sod: assert property (p_sod) else $error("sda driven high");
  property p_eod; d_evt_o == 1'b0; endproperty
  a_eod: assert property (p_eod) else $error("event driven high");
  property p_drv; $fell(d_sda_oe_n) |-> !scl; endproperty
  a_drv: assert property (p_drv) else $error("sda taken in scl high");
  property p_rel; $rose(d_sda_oe_n) |-> !scl; endproperty
  a_rel: assert property (p_rel) else $error("sda freed in scl high");
  property p_hold; $fell(d_sda_oe_n) |-> !d_sda_oe_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("ack too short");
  property p_hi; $rose(scl) |-> scl [*8]; endproperty
  a_hi: assert property (p_hi) else $error("scl high too short");
  property p_lo; $fell(scl) |-> !scl [*8]; endproperty
  a_lo: assert property (p_lo) else $error("scl low too short");
  property p_rst; $rose(arst_n) |-> d_sda_oe_n && d_evt_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("pins held at reset");
  c_ack: cover property ($fell(d_sda_oe_n));
  c_evt: cover property ($fell(d_evt_oe_n));
  c_start: cover property (scl && $fell(sda));
endmodule
`default_nettype wire

// File: temp_sensor_addr_event_regs_tb.sv
// Purpose: bench of master and sensor ends
// Assumes: straps at 101, short conversion period
// Notes: drives 1ns after rising edges
`include "tsa_map.svh"
`default_nettype none
module temp_sensor_addr_event_regs_tb
  import tsa_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  localparam int CONV = 200;
  localparam logic [6:0] TS = 7'h1d;
  logic clk_sys = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_rw = 1'b0, temp_valid = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [1:0] cmd_nbytes = 2'h0;
  logic [23:0] cmd_wdata = 24'h000000;
  logic [15:0] temp_code = 16'h0000;
  logic [15:0] rsp_data;
  logic [1:0] ee_sel;
  logic [7:0] ee_wr_data;
  logic [7:0] ee_seen = 8'h00;
  logic cmd_ready, rsp_valid, rsp_nack, conv_req, ee_rw, ee_wr_valid;
  int n_errors = 0;
  int tests_run = 0;
  tsa_bus_if i_tsa_bus_if ();
  tsa_host i_tsa_host (.clk_sys, .arst_n, .ce(1'b1), .bus(i_tsa_bus_if), .cmd_valid, .cmd_ready, .cmd_addr,
    .cmd_rw, .cmd_nbytes, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_nack);
  tsa_dev #(.CONV_CYC(CONV)) i_tsa_dev (.clk_sys, .arst_n, .ce(1'b1), .bus(i_tsa_bus_if), .strap_addr_bit2(1'b1),
    .strap_addr_bit1(1'b0), .strap_addr_bit0(1'b1), .temp_code, .temp_valid, .ee_rd_data(ee_seen), .conv_req,
    .ee_sel, .ee_rw, .ee_wr_data, .ee_wr_valid);
  tsa_props i_tsa_props (.clk_sys, .arst_n, .scl(i_tsa_bus_if.scl), .sda(i_tsa_bus_if.sda),
    .d_sda_o(i_tsa_bus_if.d_sda_o), .d_sda_oe_n(i_tsa_bus_if.d_sda_oe_n), .d_evt_o(i_tsa_bus_if.d_evt_o),
    .d_evt_oe_n(i_tsa_bus_if.d_evt_oe_n));
  logic [1:0] sel_seen = 2'h0;
  always @(posedge clk_sys)
  begin
    if (ee_wr_valid === 1'b1)
    begin
      ee_seen <= ee_wr_data;
      sel_seen <= ee_sel;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [6:0] a, input logic rw, input logic [1:0] nb, input logic [23:0] wd);
    cmd_addr = a;
    cmd_rw = rw;
    cmd_nbytes = nb;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    #50;
    cmd_valid = 1'b0;
    for (int k = 0; k < 3000 && rsp_valid !== 1'b1; k++)
      #50;
    if (rsp_valid !== 1'b1 || cmd_ready !== 1'b1)
      n_errors++;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    cmd(TS, 1'b0, 2'h3, {p, d});
  endtask
  task automatic rdc(input logic [7:0] p, input logic [15:0] e);
    cmd(TS, 1'b0, 2'h1, {p, 16'h0000});
    cmd(TS, 1'b1, 2'h2, 24'h000000);
    check(rsp_data, e);
  endtask
  task automatic tv(input logic [15:0] t, input logic e);
    temp_code = t;
    temp_valid = 1'b1;
    #50;
    temp_valid = 1'b0;
    #150;
    check(i_tsa_bus_if.evt_line, e);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    cmd(TS, 1'b1, 2'h2, 24'h000000);
    check(rsp_data, `TSA_CAP_RST);
    for (int p = 1; p < 5; p++)
      rdc(8'(p), `TSA_REG_RST);
    wr(`TSA_PTR_UP, 16'h0320);
    rdc(`TSA_PTR_UP, 16'h0320);
    wr(`TSA_PTR_TEMP, 16'h1234);
    check(rsp_nack, 1'b0);
    rdc(`TSA_PTR_TEMP, 16'h0000);
    rdc(8'h08, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_addr();
    logic [3:0] ty [5] = '{4'ha, 4'h6, 4'h3, 4'h5, 4'hc};
    for (int i = 0; i < 13; i++)
    begin
      cmd(i < 5 ? {ty[i], 3'h5} : {4'h3, 3'(i - 5)}, 1'b0, 2'h0, 24'h000000);
      check(rsp_nack, i == 3 || i == 4 || (i > 4 && i != 10));
    end
    cmd({4'ha, 3'h5}, 1'b0, 2'h1, 24'h5c0000);
    check(ee_seen, 8'h5c);
    check(sel_seen, 2'h1);
    check(ee_rw, 1'b0);
    cmd({4'h6, 3'h5}, 1'b1, 2'h1, 24'h000000);
    check(rsp_data, 16'h005c);
    check(ee_rw, 1'b1);
    $display("t_addr done");
  endtask
  task automatic t_evt();
    wr(`TSA_PTR_CRIT, 16'h0500);
    wr(`TSA_PTR_CFG, 16'h0208);
    tv(16'h0400, 1'b0);
    rdc(`TSA_PTR_TEMP, 16'h0400);
    rdc(`TSA_PTR_CFG, 16'h0218);
    tv(16'h0310, 1'b0);
    tv(16'h0300, 1'b1);
    wr(`TSA_PTR_CFG, 16'h0209);
    tv(16'h0400, 1'b0);
    tv(16'h0300, 1'b0);
    wr(`TSA_PTR_CFG, 16'h0229);
    check(i_tsa_bus_if.evt_line, 1'b1);
    tv(16'h0300, 1'b1);
    wr(`TSA_PTR_CFG, 16'h020c);
    tv(16'h0600, 1'b0);
    tv(16'h04f0, 1'b0);
    tv(16'h04e0, 1'b1);
    wr(`TSA_PTR_CFG, 16'h020e);
    check(i_tsa_bus_if.evt_line, 1'b0);
    tv(16'h0600, 1'b1);
    for (int k = 0; k <= CONV && conv_req !== 1'b1; k++)
      #50;
    check(conv_req, 1'b1);
    $display("t_evt done");
  endtask
  initial
  begin
    forever #25 clk_sys = !clk_sys;
  end
  initial
  begin
    #776;
    arst_n = 1'b1;
    t_regs();
    t_addr();
    t_evt();
    stop_test();
  end
  initial
  begin
    #2000000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
